/* File: hw/vim_pkg.sv */
// Package for the vectored interrupt map: exception numbers, vector layout and carriers
package vim_pkg;

    // ----------------------------------------
    // Table geometry
    // ----------------------------------------
    localparam int unsigned EXC_FIRST = 14;
    localparam int unsigned EXC_LAST = 115;
    localparam int unsigned SYS_EXC_COUNT = 15;
    localparam int unsigned IRQ_ENTRY_COUNT = 115;
    localparam int unsigned NUM_SRC = EXC_LAST - EXC_FIRST + 1;
    localparam int unsigned PRIO_LEVELS = 8;
    localparam int unsigned PRIO_W = 3;
    localparam int unsigned NUM_W = 7;
    localparam int unsigned IDX_W = 7;
    localparam int unsigned VEC_W = 10;
    localparam int unsigned VEC_STRIDE = 4;
    localparam int unsigned STACK_DEPTH = PRIO_LEVELS;
    localparam int unsigned DEPTH_W = 4;

    // ----------------------------------------
    // Exception numbers of connected sources
    // ----------------------------------------
    localparam int unsigned EXC_DEFERRED = 14;
    localparam int unsigned EXC_TICK = 15;
    localparam int unsigned EXC_POWER_FAIL = 16;
    localparam int unsigned EXC_WDOG_A = 17;
    localparam int unsigned EXC_RANDOM = 20;
    localparam int unsigned EXC_TIMER0 = 21;
    localparam int unsigned EXC_LP_TIMER = 25;
    localparam int unsigned EXC_ASYNC_A = 30;
    localparam int unsigned EXC_SYNC_A = 32;
    localparam int unsigned EXC_SYNC_B = 33;
    localparam int unsigned EXC_FLASH = 39;
    localparam int unsigned EXC_PORT_A = 40;
    localparam int unsigned EXC_PORT_B = 41;
    localparam int unsigned EXC_ASYNC_C = 50;
    localparam int unsigned EXC_WDOG_B = 73;
    localparam int unsigned EXC_ECC = 98;
    localparam int unsigned TIMER_COUNT = 4;

    // ----------------------------------------
    // Vector offsets, one word per entry
    // ----------------------------------------
    localparam logic [VEC_W-1:0] VEC_DEFERRED = VEC_W'(EXC_DEFERRED * VEC_STRIDE);
    localparam logic [VEC_W-1:0] VEC_TICK = VEC_W'(EXC_TICK * VEC_STRIDE);
    localparam logic [VEC_W-1:0] VEC_WDOG_A = VEC_W'(EXC_WDOG_A * VEC_STRIDE);
    localparam logic [VEC_W-1:0] VEC_RANDOM = VEC_W'(EXC_RANDOM * VEC_STRIDE);
    localparam logic [VEC_W-1:0] VEC_LP_TIMER = VEC_W'(EXC_LP_TIMER * VEC_STRIDE);
    localparam logic [VEC_W-1:0] VEC_ASYNC_A = VEC_W'(EXC_ASYNC_A * VEC_STRIDE);
    localparam logic [VEC_W-1:0] VEC_SYNC_A = VEC_W'(EXC_SYNC_A * VEC_STRIDE);
    localparam logic [VEC_W-1:0] VEC_SYNC_B = VEC_W'(EXC_SYNC_B * VEC_STRIDE);
    localparam logic [VEC_W-1:0] VEC_FLASH = VEC_W'(EXC_FLASH * VEC_STRIDE);
    localparam logic [VEC_W-1:0] VEC_PORT_A = VEC_W'(EXC_PORT_A * VEC_STRIDE);
    localparam logic [VEC_W-1:0] VEC_PORT_B = VEC_W'(EXC_PORT_B * VEC_STRIDE);
    localparam logic [VEC_W-1:0] VEC_ASYNC_C = VEC_W'(EXC_ASYNC_C * VEC_STRIDE);
    localparam logic [VEC_W-1:0] VEC_WDOG_B = VEC_W'(EXC_WDOG_B * VEC_STRIDE);
    localparam logic [VEC_W-1:0] VEC_ECC = VEC_W'(EXC_ECC * VEC_STRIDE);

    // ----------------------------------------
    // Reset values and idle codes
    // ----------------------------------------
    localparam logic [PRIO_W:0] RUN_PRIO_IDLE = 4'h8;
    localparam logic [NUM_W-1:0] NUM_NONE = 7'h00;
    localparam logic [VEC_W-1:0] VEC_NONE = 10'h000;
    localparam logic [DEPTH_W-1:0] DEPTH_RST = 4'h0;

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic deferred_service_request;
        logic core_tick_timer_request;
        logic power_fail_request;
        logic window_watchdog_a_request;
        logic random_source_request;
        logic [TIMER_COUNT-1:0] timer_request;
        logic low_power_timer_request;
        logic async_serial_a_request;
        logic sync_serial_a_request;
        logic sync_serial_b_request;
        logic flash_ctrl_request;
        logic pin_port_a_request;
        logic pin_port_b_request;
        logic async_serial_c_request;
        logic window_watchdog_b_request;
        logic error_coding_request;
    } vim_sources_s;

    typedef struct packed {
        logic valid;
        logic [NUM_W-1:0] number;
        logic [VEC_W-1:0] vector;
        logic [PRIO_W-1:0] prio;
    } vim_entry_s;

    typedef struct packed {
        logic [NUM_W-1:0] number;
        logic [PRIO_W-1:0] prio;
    } vim_frame_s;

endpackage

/* File: hw/vim_arbiter.sv */
// Priority arbiter: lowest level wins, ties go to the lowest exception number
`timescale 1ns/10ps
`default_nettype none
module vim_arbiter
    import vim_pkg::*;
#(
    parameter int unsigned N = 4
) (
    // Candidates
    input wire logic [N-1:0] cand_valid,
    input wire logic [N-1:0][PRIO_W-1:0] cand_prio,
    // Winner
    output logic win_valid,
    output logic [IDX_W-1:0] win_index,
    output logic [PRIO_W-1:0] win_prio
);
    always_comb begin
        win_valid = 1'b0;
        win_index = '0;
        win_prio = '1;
        // Strict less-than keeps the lower index on equal levels
        for (int i = 0; i < N; i++) begin
            if (cand_valid[i] && (!win_valid || cand_prio[i] < win_prio)) begin
                win_valid = 1'b1;
                win_index = IDX_W'(i);
                win_prio = cand_prio[i];
            end
        end
    end
endmodule
`default_nettype wire

/* File: hw/vim_top.sv */
// Nested prioritised exception controller with fixed vector map
`timescale 1ns/10ps
`default_nettype none

module vim_top
    import vim_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Peripheral and system requests, one-cycle pulses
    input wire vim_pkg::vim_sources_s sources,
    // Per-source configuration, index is exception number minus 14
    input wire logic [vim_pkg::NUM_SRC-1:0] src_enable,
    input wire logic [vim_pkg::NUM_SRC-1:0][vim_pkg::PRIO_W-1:0] src_prio,
    // Core handshake
    input wire logic core_accept,
    input wire logic core_return,
    // Presented request
    output logic exc_valid,
    output logic [vim_pkg::NUM_W-1:0] exc_number,
    output logic [vim_pkg::VEC_W-1:0] exc_vector,
    output logic [vim_pkg::PRIO_W-1:0] exc_prio,
    // Service state
    output logic [vim_pkg::NUM_W-1:0] active_number,
    output logic [vim_pkg::DEPTH_W-1:0] nest_depth,
    output logic [vim_pkg::NUM_SRC-1:0] pending
);
    import vim_pkg::*;

    // ------------------------------------------------
    // Source map
    // ------------------------------------------------
    // Reserved slots simply never get a bit set here
    // reserved stay unset
    logic [NUM_SRC-1:0] src_set;

    always_comb begin
        src_set = '0;
        src_set[EXC_DEFERRED - EXC_FIRST] = sources.deferred_service_request;
        src_set[EXC_TICK - EXC_FIRST] = sources.core_tick_timer_request;
        src_set[EXC_POWER_FAIL - EXC_FIRST] = sources.power_fail_request;
        src_set[EXC_WDOG_A - EXC_FIRST] = sources.window_watchdog_a_request;
        src_set[EXC_RANDOM - EXC_FIRST] = sources.random_source_request;
        for (int t = 0; t < TIMER_COUNT; t++) begin
            src_set[EXC_TIMER0 - EXC_FIRST + t] = sources.timer_request[t];
        end
        src_set[EXC_LP_TIMER - EXC_FIRST] = sources.low_power_timer_request;
        src_set[EXC_ASYNC_A - EXC_FIRST] = sources.async_serial_a_request;
        src_set[EXC_SYNC_A - EXC_FIRST] = sources.sync_serial_a_request;
        src_set[EXC_SYNC_B - EXC_FIRST] = sources.sync_serial_b_request;
        src_set[EXC_FLASH - EXC_FIRST] = sources.flash_ctrl_request;
        src_set[EXC_PORT_A - EXC_FIRST] = sources.pin_port_a_request;
        src_set[EXC_PORT_B - EXC_FIRST] = sources.pin_port_b_request;
        src_set[EXC_ASYNC_C - EXC_FIRST] = sources.async_serial_c_request;
        src_set[EXC_WDOG_B - EXC_FIRST] = sources.window_watchdog_b_request;
        src_set[EXC_ECC - EXC_FIRST] = sources.error_coding_request;
    end

    // ------------------------------------------------
    // State
    // ------------------------------------------------
    logic [NUM_SRC-1:0] pend_q;
    logic [NUM_SRC-1:0] pend_d;
    vim_frame_s stack_q [STACK_DEPTH];
    logic [DEPTH_W-1:0] depth_q;
    logic [DEPTH_W-1:0] depth_d;
    vim_entry_s pres_q;
    vim_entry_s pres_d;
    logic [NUM_W-1:0] active_q;
    logic [NUM_W-1:0] active_d;

    // ------------------------------------------------
    // Arbitration
    // ------------------------------------------------
    logic [NUM_SRC-1:0] cand_valid;
    logic win_valid;
    logic [IDX_W-1:0] win_index;
    logic [PRIO_W-1:0] win_prio;

    assign cand_valid = pend_q & src_enable;

    vim_arbiter #(
        .N(NUM_SRC)
    ) u_arbiter (
        .cand_valid(cand_valid),
        .cand_prio(src_prio),
        .win_valid(win_valid),
        .win_index(win_index),
        .win_prio(win_prio)
    );

    // ------------------------------------------------
    // Nesting
    // ------------------------------------------------
    wire do_return = core_return && (depth_q != DEPTH_RST);
    wire do_accept = core_accept && pres_q.valid;
    wire [DEPTH_W-1:0] depth_pop = do_return ? depth_q - 4'h1 : depth_q;
    wire [DEPTH_W-1:0] depth_top = depth_q - 4'h1;
    wire [DEPTH_W-1:0] depth_under = depth_q - 4'h2;
    wire stack_has = (depth_q != DEPTH_RST);
    wire under_has = (depth_q > 4'h1);
    wire [PRIO_W:0] run_prio = stack_has ? {1'b0, stack_q[depth_top[2:0]].prio} : RUN_PRIO_IDLE;
    // Running level after a same-cycle return, so a waiting request can enter at once
    wire [PRIO_W:0] run_prio_next = do_return ? (under_has ? {1'b0, stack_q[depth_under[2:0]].prio}
                                                           : RUN_PRIO_IDLE) : run_prio;
    wire preempt_ok = win_valid && ({1'b0, win_prio} < run_prio_next);
    wire [NUM_W-1:0] win_number = NUM_W'(win_index) + NUM_W'(EXC_FIRST);
    wire [VEC_W-1:0] win_vector = VEC_W'(win_number) * VEC_W'(VEC_STRIDE);
    wire [IDX_W-1:0] pres_index = pres_q.number - NUM_W'(EXC_FIRST);

    // Set wins over the clear of the slot being taken
    assign pend_d = (pend_q & ~(do_accept ? (NUM_SRC'(1) << pres_index) : '0)) | src_set;

    assign depth_d = do_accept ? depth_pop + 4'h1 : depth_pop;

    always_comb begin
        active_d = active_q;
        if (do_accept) begin
            active_d = pres_q.number;
        end else if (do_return) begin
            active_d = under_has ? stack_q[depth_under[2:0]].number : NUM_NONE;
        end
    end

    // A presented request is withdrawn the cycle after accept so it is never taken twice
    always_comb begin
        pres_d.valid = preempt_ok && !do_accept;
        pres_d.number = preempt_ok ? win_number : NUM_NONE;
        pres_d.vector = preempt_ok ? win_vector : VEC_NONE;
        pres_d.prio = preempt_ok ? win_prio : '0;
    end

    // ------------------------------------------------
    // Registers
    // ------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pend_q <= '0;
            depth_q <= DEPTH_RST;
            pres_q <= '0;
            active_q <= NUM_NONE;
        end else begin
            pend_q <= pend_d;
            depth_q <= depth_d;
            pres_q <= pres_d;
            active_q <= active_d;
        end
    end

    // Stack frames hold no control meaning until depth covers them
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            for (int s = 0; s < STACK_DEPTH; s++) begin
                stack_q[s] <= '0;
            end
        end else if (do_accept) begin
            stack_q[depth_pop[2:0]] <= '{number: pres_q.number, prio: pres_q.prio};
        end
    end

    // ------------------------------------------------
    // Outputs
    // ------------------------------------------------
    assign exc_valid = pres_q.valid;
    assign exc_number = pres_q.number;
    assign exc_vector = pres_q.vector;
    assign exc_prio = pres_q.prio;
    assign active_number = active_q;
    assign nest_depth = depth_q;
    assign pending = pend_q;

endmodule
`default_nettype wire

/* File: tb/vim_top_chk.sv */
// Port checker for the vectored interrupt map
`timescale 1ns/10ps
`default_nettype none
module vim_top_chk
    import vim_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Requests and configuration
    input wire vim_pkg::vim_sources_s sources,
    input wire logic [vim_pkg::NUM_SRC-1:0] src_enable,
    input wire logic [vim_pkg::NUM_SRC-1:0][vim_pkg::PRIO_W-1:0] src_prio,
    input wire logic core_accept,
    input wire logic core_return,
    // Outputs watched
    input wire logic exc_valid,
    input wire logic [vim_pkg::NUM_W-1:0] exc_number,
    input wire logic [vim_pkg::VEC_W-1:0] exc_vector,
    input wire logic [vim_pkg::PRIO_W-1:0] exc_prio,
    input wire logic [vim_pkg::NUM_W-1:0] active_number,
    input wire logic [vim_pkg::DEPTH_W-1:0] nest_depth,
    input wire logic [vim_pkg::NUM_SRC-1:0] pending
);
    logic [NUM_W-1:0] idx;
    logic push_only;
    assign idx = exc_number - 7'h0E;
    assign push_only = core_accept && exc_valid && !core_return;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    a_pend_set: assert property (sources.random_source_request |=> pending[6])
        else $error("random source pulse not pending");
    a_vec_number: assert property (exc_valid |-> exc_vector == {1'b0, exc_number, 2'b00})
        else $error("vector offset not four times number");
    a_num_range: assert property (exc_valid |-> exc_number >= 7'h0E && exc_number <= 7'h73)
        else $error("presented number outside table");
    a_mask_hides: assert property (exc_valid |-> src_enable[idx] && pending[idx])
        else $error("masked or idle source presented");
    a_prio_match: assert property (exc_valid |-> exc_prio == src_prio[idx])
        else $error("presented level differs from source level");
    a_accept_push: assert property (push_only |=> !exc_valid && nest_depth == $past(nest_depth) + 4'h1
        && active_number == $past(exc_number)) else $error("accept did not push frame");
    a_return_pop: assert property (core_return && !core_accept && nest_depth != 4'h0
        |=> nest_depth == $past(nest_depth) - 4'h1) else $error("return did not pop frame");
    a_reserved_quiet: assert property (pending[5:4] == 2'h0 && !pending[17]
        && pending[55:37] == 19'h0 && pending[101:85] == 17'h0) else $error("reserved slot pending");
    a_tick_vector: assert property (exc_valid && exc_number == 7'h0F |-> exc_vector == 10'h03C)
        else $error("tick timer vector wrong");
    a_return_refused: assert property (core_return && nest_depth == 4'h0 && !(core_accept && exc_valid)
        |=> nest_depth == 4'h0) else $error("return at depth zero changed depth");
    a_swap_keep: assert property (core_accept && exc_valid && core_return && nest_depth != 4'h0
        |=> nest_depth == $past(nest_depth) && active_number == $past(exc_number))
        else $error("swap did not replace top frame");
    c_push: cover property (push_only);
    c_nest_two: cover property (nest_depth == 4'h2);
    c_masked: cover property (|(pending & ~src_enable));
    c_swap: cover property (core_accept && exc_valid && core_return);
endmodule
bind vim_top vim_top_chk u_chk (.clock(clock), .rst(rst), .sources(sources), .src_enable(src_enable),
    .src_prio(src_prio), .core_accept(core_accept), .core_return(core_return), .exc_valid(exc_valid),
    .exc_number(exc_number), .exc_vector(exc_vector), .exc_prio(exc_prio), .active_number(active_number),
    .nest_depth(nest_depth), .pending(pending));
`default_nettype wire

/* File: tb/vim_core_model.sv */
// Behavioural processor core taking and returning from exceptions
`timescale 1ns/10ps
`default_nettype none
module vim_core_model (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Presented request and scenario control
    input wire logic exc_valid,
    input wire logic take_en,
    input wire logic ret_req,
    input wire logic [3:0] take_wait,
    // Handshake
    output logic core_accept,
    output logic core_return
);
    logic [3:0] wait_q;
    // Slow answers come from take_wait; one pulse per presentation
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            core_accept <= 1'b0;
            core_return <= 1'b0;
            wait_q <= 4'h0;
        end else begin
            core_accept <= 1'b0;
            core_return <= ret_req;
            if (take_en && exc_valid && !core_accept) begin
                if (wait_q >= take_wait) begin
                    core_accept <= 1'b1;
                    wait_q <= 4'h0;
                end else begin
                    wait_q <= wait_q + 4'h1;
                end
            end else begin
                wait_q <= 4'h0;
            end
        end
    end
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// Testbench for the vectored interrupt map
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import vim_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    vim_sources_s sources = '0;
    logic [NUM_SRC-1:0] src_enable = '1;
    logic [NUM_SRC-1:0][PRIO_W-1:0] src_prio = '0;
    logic core_accept, core_return, exc_valid;
    logic take_en = 1'b0;
    logic ret_req = 1'b0;
    logic [3:0] take_wait = 4'h0;
    logic [NUM_W-1:0] exc_number, active_number;
    logic [VEC_W-1:0] exc_vector;
    logic [PRIO_W-1:0] exc_prio;
    logic [DEPTH_W-1:0] nest_depth;
    logic [NUM_SRC-1:0] pending;
    int err_total = 0;
    int total_checks = 0;
    // Source field bit position to exception number and vector offset
    int num_of[19] = '{98, 73, 50, 41, 40, 39, 33, 32, 30, 25, 21, 22, 23, 24, 20, 17, 16, 15, 14};
    int vec_of[19] = '{10'h188, 10'h124, 10'h0C8, 10'h0A4, 10'h0A0, 10'h09C, 10'h084, 10'h080, 10'h078, 10'h064,
        10'h054, 10'h058, 10'h05C, 10'h060, 10'h050, 10'h044, 10'h040, 10'h03C, 10'h038};
    always #12.5 clock = ~clock;
    vim_top dut (.clock(clock), .rst(rst), .sources(sources), .src_enable(src_enable), .src_prio(src_prio),
        .core_accept(core_accept), .core_return(core_return), .exc_valid(exc_valid), .exc_number(exc_number),
        .exc_vector(exc_vector), .exc_prio(exc_prio), .active_number(active_number),
        .nest_depth(nest_depth), .pending(pending));
    vim_core_model u_core (.clock(clock), .rst(rst), .exc_valid(exc_valid), .take_en(take_en),
        .ret_req(ret_req), .take_wait(take_wait), .core_accept(core_accept), .core_return(core_return));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic pulse(input logic [18:0] bits);
        sources = vim_sources_s'(bits);
        @(negedge clock);
        sources = '0;
    endtask
    task automatic wait_num(input int num);
        for (int i = 0; i < 20 && exc_valid !== 1'b1; i++) @(negedge clock);
        chk(32'(exc_number), num, "presented number");
    endtask
    task automatic take;
        take_en = 1'b1;
        for (int i = 0; i < 20 && core_accept !== 1'b1; i++) @(negedge clock);
        take_en = 1'b0;
        @(negedge clock);
    endtask
    task automatic give_back;
        ret_req = 1'b1;
        @(negedge clock);
        ret_req = 1'b0;
        @(negedge clock);
    endtask
    task automatic t_map;
        for (int b = 18; b >= 0; b--) begin
            pulse(19'h1 << b);
            wait_num(num_of[b]);
            chk(32'(exc_vector), vec_of[b], "vector offset");
            take;
            chk(32'(active_number), num_of[b], "active number");
            chk(32'(pending[num_of[b] - 14]), 1'b0, "pending after accept");
            give_back;
            chk(32'(nest_depth), 0, "depth after return");
        end
    endtask
    task automatic t_prio;
        for (int lv = 0; lv < 9; lv++) begin
            src_prio[25] = (lv == 8) ? 3'h3 : 3'(lv);
            src_prio[84] = (lv == 8) ? 3'h3 : 3'(7 - lv);
            pulse(19'h00021);
            wait_num((lv < 4 || lv == 8) ? 39 : 98);
            chk(32'(exc_prio), (lv == 8) ? 3 : ((lv < 4) ? lv : 7 - lv), "winning level");
            take;
            give_back;
            wait_num((lv < 4 || lv == 8) ? 98 : 39);
            take;
            give_back;
        end
        src_prio = '0;
    endtask
    task automatic t_mask;
        src_enable[16] = 1'b0;
        pulse(19'h00100);
        repeat (4) @(negedge clock);
        chk(32'(exc_valid), 0, "masked source hidden");
        chk(32'(pending[16]), 1, "masked source pending");
        src_enable[16] = 1'b1;
        wait_num(30);
        take;
        give_back;
    endtask
    task automatic t_nest;
        take_wait = 4'h3;
        src_prio[16] = 3'h6;
        src_prio[1] = 3'h1;
        src_prio[18] = 3'h6;
        pulse(19'h00100);
        wait_num(30);
        take;
        pulse(19'h20000);
        wait_num(15);
        take;
        chk(32'(nest_depth), 2, "nested depth");
        pulse(19'h00080);
        repeat (4) @(negedge clock);
        chk(32'(exc_valid), 0, "lower level held back");
        give_back;
        chk(32'(active_number), 30, "interrupted one resumes");
        repeat (3) @(negedge clock);
        chk(32'(exc_valid), 0, "equal level does not preempt");
        give_back;
        wait_num(32);
        take;
        give_back;
        src_prio = '0;
        take_wait = 4'h0;
    endtask
    // Accept and return on one edge replace the top frame; a return with nothing active is ignored
    task automatic t_swap;
        src_prio[16] = 3'h6;
        src_prio[1] = 3'h1;
        pulse(19'h00100);
        wait_num(30);
        take;
        pulse(19'h20000);
        wait_num(15);
        take_en = 1'b1;
        ret_req = 1'b1;
        @(negedge clock);
        take_en = 1'b0;
        ret_req = 1'b0;
        @(negedge clock);
        chk(32'(nest_depth), 1, "depth after swap");
        chk(32'(active_number), 15, "top frame replaced");
        give_back;
        chk(32'(nest_depth), 0, "empty after swap");
        give_back;
        chk(32'(nest_depth), 0, "return at depth zero ignored");
        chk(32'(active_number), 0, "idle after ignored return");
        src_prio = '0;
    endtask
    initial begin
        repeat (16) @(negedge clock);
        rst = 1'b0;
        @(negedge clock);
        chk(32'(exc_valid), 0, "idle after reset");
        chk(32'(|pending), 0, "nothing pending after reset");
        t_map();
        t_prio();
        t_mask();
        t_nest();
        t_swap();
        final_report();
    end
    // Whole run needs about 300 cycles
    initial begin
        #(25 * 5000);
        err_total++;
        $display("watchdog expired at %0t", $time);
        final_report();
    end
endmodule
`default_nettype wire
